// file: pkg/srr_regs.svh
// register offsets, field positions, reset values and key codes of the row repair sequencer
`ifndef SRR_REGS_SVH
`define SRR_REGS_SVH
`define SRR_ID_OFF 8'h00
`define SRR_CTRL_OFF 8'h04
`define SRR_STAT_OFF 8'h08
`define SRR_RSRC_OFF 8'h0c
`define SRR_ROW_BASE 8'h40
`define SRR_ROW_MASK 8'hc0
`define SRR_CTRL_WL_LSB 0
`define SRR_CTRL_WL_MSB 5
`define SRR_CTRL_BYPASS_BIT 8
`define SRR_CTRL_WL_RESET 6'h0c
`define SRR_CTRL_BYPASS_RESET 1'b0
`define SRR_RSRC_RESET 16'hffff
`define SRR_ID_HARD_BIT 7
`define SRR_ID_SOFT_BIT 6
`define SRR_MR_BASE 3'h0
`define SRR_MR_REPAIR 3'h4
`define SRR_MR_SOFT_EN_BIT 5
`define SRR_KEY_LOW 7'h7f
`define SRR_KEY1 5'h19
`define SRR_KEY2 5'h0f
`define SRR_KEY3 5'h17
`define SRR_KEY4 5'h07
`define SRR_BURST_BEATS 2'h3
`define SRR_HIGH_BEATS 2'h1
`endif

// file: pkg/srr_pkg.sv
// types shared by the soft row repair sequencer
package srr_pkg;
    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
    } srr_ca_t;

    typedef enum logic [10:0] {
        SRR_OFF = 11'h001,
        SRR_KEY1 = 11'h002,
        SRR_KEY2 = 11'h004,
        SRR_KEY3 = 11'h008,
        SRR_KEY4 = 11'h010,
        SRR_ARMED = 11'h020,
        SRR_ROW = 11'h040,
        SRR_WAITWL = 11'h080,
        SRR_DATA = 11'h100,
        SRR_RECOV = 11'h200,
        SRR_DONE = 11'h400
    } srr_state_t;
endpackage

// file: src/srr_sequencer.sv
// soft row repair sequencer: command decode, guard keys, repair table, wishbone registers
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srr_regs.svh"

// Operation
// - repair mode register bit 5 set enters soft repair, cleared leaves it.
// - while soft repair is enabled every DQ output is driven high.
// - four base mode register keys with fixed A11..A7 codes, A6:0 all ones.
// - wrong key order or other mode write leaves repair disabled, a no-op.
// - after a broken entry, activate and write act as ordinary accesses.
// - repair only when every DQ is low in all eight burst bits.
// - DQ high for the first two clocks skips repair and keeps data.
// - precharge after write recovery; repair completes within that window.
// - the whole sequence may repeat for each further row.
// - identifier bit 7 reports hard repair, bit 6 soft repair support.
// - activate opens a row in a bank until precharge closes it.
// - one repaired row per bank; newer replaces older; no resource ignores.
// - reset drops all soft repair information.
module srr_sequencer import srr_pkg::*; #(
    parameter int NBANK = 16,
    parameter int DQW = 8,
    parameter logic HARD_SUPPORT = 1'b1,
    parameter logic SOFT_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // command/address, one command per clock
    input wire srr_ca_t ca,
    // write data: low half rising beat, high half falling beat
    input wire logic [2*DQW-1:0] dq_in,
    // data outputs
    output logic [DQW-1:0] dq_out,
    output logic dq_oe,
    // status
    output logic soft_en,
    output logic repair_done,
    output logic act_remap,
    output logic [3:0] act_bank
);
    localparam int BW = $clog2(NBANK);

    srr_state_t state;
    logic [5:0] wl;
    logic bypass;
    logic [NBANK-1:0] rsrc;
    logic [NBANK-1:0] bank_open;
    logic [17:0] open_row [NBANK];
    logic [NBANK-1:0] rep_valid;
    logic [17:0] rep_row [NBANK];
    logic [BW-1:0] tgt_bank;
    logic [17:0] tgt_row;
    logic [5:0] wl_cnt;
    logic [1:0] beat;
    logic all_low;
    logic all_high;
    logic [1:0] last_result;

    // command decode
    logic sel_cmd;
    logic is_act;
    logic is_mrs;
    logic is_wr;
    logic is_pre;
    logic [2:0] mr_num;
    logic [BW-1:0] cmd_bank;
    logic key_fmt;
    logic [4:0] key_code;
    logic [4:0] want_key;
    logic beat_low;
    logic beat_high;
    logic low_ok;

    assign sel_cmd = !ca.cs_n;
    assign is_act = sel_cmd && !ca.act_n;
    assign is_mrs = sel_cmd && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;
    assign is_wr = sel_cmd && ca.act_n && ca.ras_n && !ca.cas_n && !ca.we_n;
    assign is_pre = sel_cmd && ca.act_n && !ca.ras_n && ca.cas_n && !ca.we_n;
    assign mr_num = {ca.bg[0], ca.ba};
    assign cmd_bank = BW'({ca.bg, ca.ba});
    // a key needs bank group and bank zero and the low address bits all ones
    assign key_fmt = (ca.bg == 2'h0) && (ca.ba == 2'h0) && (ca.addr[6:0] == `SRR_KEY_LOW);
    assign key_code = ca.addr[11:7];
    assign beat_low = (dq_in == '0);
    assign beat_high = (dq_in == '1);
    assign low_ok = all_low && beat_low;

    always_comb begin
        case (state)
            SRR_KEY1: want_key = `SRR_KEY1;
            SRR_KEY2: want_key = `SRR_KEY2;
            SRR_KEY3: want_key = `SRR_KEY3;
            SRR_KEY4: want_key = `SRR_KEY4;
            default: want_key = 5'h00;
        endcase
    end

    // repair mode enable bit and main sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SRR_OFF;
            soft_en <= 1'b0;
        end else if (is_mrs && mr_num == `SRR_MR_REPAIR) begin
            soft_en <= ca.addr[`SRR_MR_SOFT_EN_BIT];
            if (!ca.addr[`SRR_MR_SOFT_EN_BIT]) begin
                state <= SRR_OFF;
            end else if (bypass) begin
                state <= SRR_ARMED;
            end else begin
                state <= SRR_KEY1;
            end
        end else begin
            case (state)
                SRR_OFF: state <= SRR_OFF;
                SRR_KEY1, SRR_KEY2, SRR_KEY3, SRR_KEY4: begin
                    if (is_mrs) begin
                        if (mr_num == `SRR_MR_BASE && key_fmt && key_code == want_key) begin
                            case (state)
                                SRR_KEY1: state <= SRR_KEY2;
                                SRR_KEY2: state <= SRR_KEY3;
                                SRR_KEY3: state <= SRR_KEY4;
                                default: state <= SRR_ARMED;
                            endcase
                        end else begin
                            state <= SRR_DONE;
                        end
                    end else if (is_act || is_wr) begin
                        state <= SRR_DONE;
                    end
                end
                SRR_ARMED: begin
                    if (is_act) begin
                        state <= SRR_ROW;
                    end
                end
                SRR_ROW: begin
                    if (is_wr && cmd_bank == tgt_bank) begin
                        state <= SRR_WAITWL;
                    end else if (is_pre && cmd_bank == tgt_bank) begin
                        state <= SRR_DONE;
                    end
                end
                SRR_WAITWL: begin
                    // leave one edge early so the first beat is taken exactly wl after the write
                    if (wl_cnt <= 6'h2) begin
                        state <= SRR_DATA;
                    end
                end
                SRR_DATA: begin
                    if (beat == `SRR_BURST_BEATS) begin
                        state <= SRR_RECOV;
                    end
                end
                SRR_RECOV: begin
                    if (is_pre && cmd_bank == tgt_bank) begin
                        state <= SRR_DONE;
                    end
                end
                SRR_DONE: state <= SRR_DONE;
                default: state <= SRR_OFF;
            endcase
        end
    end

    // seed row capture
    always_ff @(posedge clk) begin
        if (rst) begin
            tgt_bank <= '0;
            tgt_row <= 18'h00000;
        end else if (state == SRR_ARMED && is_act) begin
            tgt_bank <= cmd_bank;
            tgt_row <= ca.addr;
        end
    end

    // write latency wait and burst check
    always_ff @(posedge clk) begin
        if (rst) begin
            wl_cnt <= 6'h00;
            beat <= 2'h0;
            all_low <= 1'b1;
            all_high <= 1'b1;
        end else if (state == SRR_ROW && is_wr) begin
            wl_cnt <= wl;
            beat <= 2'h0;
            all_low <= 1'b1;
            all_high <= 1'b1;
        end else if (state == SRR_WAITWL) begin
            wl_cnt <= wl_cnt - 6'h1;
        end else if (state == SRR_DATA) begin
            beat <= beat + 2'h1;
            all_low <= all_low && beat_low;
            if (beat <= `SRR_HIGH_BEATS) begin
                all_high <= all_high && beat_high;
            end
        end
    end

    // repair table, one row per bank, cleared by reset
    genvar gb;
    generate
        for (gb = 0; gb < NBANK; gb++) begin : g_bank
            always_ff @(posedge clk) begin
                if (rst) begin
                    rep_valid[gb] <= 1'b0;
                    rep_row[gb] <= 18'h00000;
                end else if (state == SRR_DATA && beat == `SRR_BURST_BEATS
                        && low_ok && rsrc[gb] && tgt_bank == BW'(gb)) begin
                    rep_valid[gb] <= 1'b1;
                    rep_row[gb] <= tgt_row;
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    bank_open[gb] <= 1'b0;
                    open_row[gb] <= 18'h00000;
                end else if (is_act && cmd_bank == BW'(gb)) begin
                    bank_open[gb] <= 1'b1;
                    open_row[gb] <= ca.addr;
                end else if (is_pre && (ca.addr[10] || cmd_bank == BW'(gb))) begin
                    bank_open[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // result: 1 repaired, 2 skipped by high data, 3 undefined pattern or no resource
    always_ff @(posedge clk) begin
        if (rst) begin
            last_result <= 2'h0;
            repair_done <= 1'b0;
        end else if (state == SRR_DATA && beat == `SRR_BURST_BEATS) begin
            repair_done <= low_ok && rsrc[tgt_bank];
            if (low_ok && rsrc[tgt_bank]) begin
                last_result <= 2'h1;
            end else if (all_high) begin
                last_result <= 2'h2;
            end else begin
                last_result <= 2'h3;
            end
        end else begin
            repair_done <= 1'b0;
        end
    end

    // ordinary activates hitting a repaired row are flagged as remapped
    always_ff @(posedge clk) begin
        if (rst) begin
            act_remap <= 1'b0;
            act_bank <= 4'h0;
        end else begin
            act_remap <= is_act && state != SRR_ARMED
                && rep_valid[cmd_bank] && rep_row[cmd_bank] == ca.addr;
            if (is_act) begin
                act_bank <= {ca.bg, ca.ba};
            end
        end
    end

    // dq driven high from one clock after soft_en rises until one clock after it falls
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_oe <= 1'b0;
            dq_out <= '0;
        end else begin
            dq_oe <= soft_en;
            dq_out <= '1;
        end
    end

    // wishbone: ack one cycle after the strobe, dropped the cycle after
    logic wb_req;
    logic [31:0] rd_data;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        rd_data = 32'h00000000;
        if ((wb_adr_i & `SRR_ROW_MASK) == `SRR_ROW_BASE) begin
            if (32'(wb_adr_i[5:2]) < NBANK) begin
                rd_data = {rep_valid[wb_adr_i[5:2]], 13'h0000, rep_row[wb_adr_i[5:2]]};
            end
        end else begin
            case (wb_adr_i)
                `SRR_ID_OFF: begin
                    rd_data[`SRR_ID_HARD_BIT] = HARD_SUPPORT;
                    rd_data[`SRR_ID_SOFT_BIT] = SOFT_SUPPORT;
                end
                `SRR_CTRL_OFF: begin
                    rd_data[`SRR_CTRL_WL_MSB:`SRR_CTRL_WL_LSB] = wl;
                    rd_data[`SRR_CTRL_BYPASS_BIT] = bypass;
                end
                `SRR_STAT_OFF: rd_data = {bank_open, 3'h0, last_result, state};
                `SRR_RSRC_OFF: rd_data = {16'h0000, rsrc};
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req && !wb_we_i ? rd_data : 32'h00000000;
        end
    end

    // control and resource registers steer the sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            wl <= `SRR_CTRL_WL_RESET;
            bypass <= `SRR_CTRL_BYPASS_RESET;
            rsrc <= `SRR_RSRC_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            // a write lands on the edge at which the master sees ack
            if (wb_adr_i == `SRR_CTRL_OFF) begin
                if (wb_sel_i[0]) begin
                    wl <= wb_dat_i[`SRR_CTRL_WL_MSB:`SRR_CTRL_WL_LSB];
                end
                if (wb_sel_i[1]) begin
                    bypass <= wb_dat_i[`SRR_CTRL_BYPASS_BIT];
                end
            end
            if (wb_adr_i == `SRR_RSRC_OFF) begin
                if (wb_sel_i[0]) begin
                    rsrc[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    rsrc[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/srr_sequencer_asserts.sv
// port checker of the soft row repair sequencer
`timescale 1ns/1ps
`default_nettype none
`include "srr_regs.svh"
module srr_sequencer_asserts import srr_pkg::*; #(
    parameter int DQW = 8,
    parameter logic HARD_SUPPORT = 1'b1,
    parameter logic SOFT_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // command link
    input wire srr_ca_t ca,
    input wire logic [2*DQW-1:0] dq_in,
    input wire logic [DQW-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic soft_en,
    input wire logic repair_done,
    input wire logic [3:0] act_bank
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_mr4(logic v);
        !ca.cs_n && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n
            && {ca.bg[0], ca.ba} == `SRR_MR_REPAIR && ca.addr[`SRR_MR_SOFT_EN_BIT] == v;
    endsequence
    sequence s_act;
        !ca.cs_n && !ca.act_n;
    endsequence
    property p_en; s_mr4(1'b1) |=> soft_en; endproperty
    a_en: assert property (p_en) else $error("enable write did not set soft_en");
    property p_dis; s_mr4(1'b0) |=> !soft_en; endproperty
    a_dis: assert property (p_dis) else $error("disable write left soft_en set");
    property p_dq_high; soft_en |-> &dq_out; endproperty
    a_dq_high: assert property (p_dq_high) else $error("dq_out not all high");
    property p_oe; 1'b1 |=> dq_oe == $past(soft_en); endproperty
    a_oe: assert property (p_oe) else $error("dq_oe does not follow soft_en");
    property p_done;
        repair_done |-> $past(dq_in, 1) == '0 && $past(dq_in, 2) == '0
            && $past(dq_in, 3) == '0 && $past(dq_in, 4) == '0;
    endproperty
    a_done: assert property (p_done) else $error("repair with nonzero burst data");
    property p_done_en; repair_done |-> $past(soft_en); endproperty
    a_done_en: assert property (p_done_en) else $error("repair outside repair mode");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a one cycle ack");
    property p_id;
        wb_ack_o && $past(wb_cyc_i && !wb_we_i && wb_adr_i == `SRR_ID_OFF)
            |-> wb_dat_o[7:6] == {HARD_SUPPORT, SOFT_SUPPORT};
    endproperty
    a_id: assert property (p_id) else $error("identifier bits wrong");
    property p_rst; $past(rst) |-> !soft_en && !dq_oe && !repair_done; endproperty
    a_rst: assert property (p_rst) else $error("repair state survives reset");
    property p_bank; s_act |=> act_bank == $past({ca.bg, ca.ba}); endproperty
    a_bank: assert property (p_bank) else $error("act_bank not the activated bank");
endmodule
bind srr_sequencer srr_sequencer_asserts #(.DQW(DQW), .HARD_SUPPORT(HARD_SUPPORT),
    .SOFT_SUPPORT(SOFT_SUPPORT)) u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ca(ca), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .soft_en(soft_en), .repair_done(repair_done), .act_bank(act_bank));
`default_nettype wire

// file: verif/srr_ctrl_model.sv
// memory controller model driving the repair command sequence
`timescale 1ns/1ps
`default_nettype none
`include "srr_regs.svh"
module srr_ctrl_model import srr_pkg::*; #(
    parameter int MOD = 4,
    parameter int RCD = 3,
    parameter int WRR = 4,
    parameter int PGX = 5
) (
    // clock
    input wire logic clk,
    // command and write data towards the device
    output var srr_ca_t ca,
    output logic [15:0] dq_in
);
    logic [4:0] kv [4] = '{`SRR_KEY1, `SRR_KEY2, `SRR_KEY3, `SRR_KEY4};
    initial begin
        ca = {5'h1f, 22'h0};
        dq_in = '1;
    end
    // deselected cycles scramble the address so stale values never look valid
    task automatic cmd(input logic [4:0] c, input logic [3:0] b, input logic [17:0] a,
            input int gap);
        @(posedge clk);
        ca <= {c, b, a};
        repeat (gap) begin
            @(posedge clk);
            ca <= {5'h1f, ~ca[21:0]};
        end
    endtask
    // only sequence commands, never a refresh, banks idle on entry
    task automatic repair(input logic [3:0] b, input logic [17:0] r, input int wl,
            input logic ok, input logic keys, input logic [63:0] d);
        cmd(5'b01000, 4'h4, 18'h20, MOD);
        if (keys) begin
            for (int i = 0; i < 4; i++) begin
                cmd(5'b01000, 4'h0, {6'h0, kv[ok ? i : i ^ 1], `SRR_KEY_LOW}, MOD);
            end
        end
        cmd(5'b00111, b, r, RCD);
        cmd(5'b01100, b, 18'h3ff, wl - 1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dq_in <= d[16*i +: 16];
        end
        @(posedge clk);
        dq_in <= '1;
        repeat (WRR) @(posedge clk);
        cmd(5'b01010, b, 18'h0, PGX);
        cmd(5'b01000, 4'h4, 18'h0, MOD);
    endtask
endmodule
`default_nettype wire

// file: verif/tb_soft_row_repair_sequencer.sv
// self-checking bench of the soft row repair sequencer
`timescale 1ns/1ps
`default_nettype none
`include "srr_regs.svh"
module tb_soft_row_repair_sequencer import srr_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [46:0] wbq = '0;
    logic [31:0] wb_dat_o, rd;
    logic [31:0] rows [16];
    logic wb_ack_o, dq_oe, soft_en, repair_done, act_remap;
    logic [7:0] dq_out;
    logic [3:0] act_bank;
    logic [15:0] dq_in;
    srr_ca_t ca;
    int bad_count = 0;
    int comparisons = 0;
    int dones = 0;
    int remaps = 0;
    srr_sequencer dut (.clk(clk), .rst(rst), .wb_cyc_i(wbq[46]), .wb_stb_i(wbq[45]),
        .wb_we_i(wbq[44]), .wb_sel_i(wbq[43:40]), .wb_adr_i(wbq[39:32]),
        .wb_dat_i(wbq[31:0]), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ca(ca),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .soft_en(soft_en),
        .repair_done(repair_done), .act_remap(act_remap), .act_bank(act_bank));
    srr_ctrl_model ctl (.clk(clk), .ca(ca), .dq_in(dq_in));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (repair_done === 1'b1) dones++;
        if (act_remap === 1'b1) remaps++;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wbq <= {2'b11, we, 4'hf, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk("ack", 0, 1);
        q = wb_dat_o;
        wbq <= '0;
    endtask
    // all-low burst repairs if the bank has a resource; first two beats high skips; anything else mixed or no resource
    function automatic logic [1:0] res(input logic [63:0] d, input logic rs);
        if (d == 64'h0 && rs) return 2'h1;
        if (d[31:0] == 32'hffffffff) return 2'h2;
        return 2'h3;
    endfunction
    initial begin
        logic [3:0] b;
        logic [17:0] r;
        logic [63:0] d;
        logic [15:0] m;
        logic byp, ok;
        int k, wl, dn, rm;
        k = $urandom(32'h0124ef5c);
        foreach (rows[i]) rows[i] = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(0, `SRR_CTRL_OFF, 0, rd);
        chk("wl", rd & 32'h13f, 32'(`SRR_CTRL_WL_RESET));
        wb(1, `SRR_ID_OFF, 0, rd);
        wb(0, `SRR_ID_OFF, 0, rd);
        chk("ident", rd & 32'hc0, 32'hc0);
        wb(0, 8'h20, 0, rd);
        chk("unmapped", rd, 0);
        for (int n = 0; n < 24; n++) begin
            b = 4'($urandom);
            r = 18'($urandom);
            k = (n < 4) ? n : $urandom % 4;
            wl = 2 + $urandom % 14;
            byp = (k != 3) && ($urandom % 4 == 0);
            ok = (k != 3);
            m = (n % 5 == 4) ? ~(16'h1 << b) : 16'hffff;
            d = (k == 0 || k == 3) ? 64'h0 : (k == 1) ? {32'($urandom), 32'hffffffff}
                : 64'h1 << ($urandom % 64);
            wb(1, `SRR_CTRL_OFF, {23'h0, byp, 2'h0, 6'(wl)}, rd);
            wb(1, `SRR_RSRC_OFF, {16'h0, m}, rd);
            dn = dones;
            ctl.repair(b, r, wl, ok, !byp, d);
            chk("done", dones - dn, 32'(d == 64'h0 && ok && m[b]));
            chk("mode_off", 32'({soft_en, dq_oe, dq_out}), 32'h000000ff);
            if (d == 64'h0 && ok && m[b]) rows[b] = {1'b1, 13'h0, r};
            if (ok) begin
                wb(0, `SRR_STAT_OFF, 0, rd);
                chk("result", rd[12:11], res(d, m[b]));
            end
            wb(0, `SRR_ROW_BASE + {b, 2'b00}, 0, rd);
            chk("row", rd, rows[b]);
            rm = remaps;
            ctl.cmd(5'b00111, b, r, 3);
            ctl.cmd(5'b01010, b, 18'h0, 5);
            chk("bank", act_bank, b);
            chk("remap", remaps - rm, 32'(rows[b] == {1'b1, 13'h0, r}));
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wb(0, `SRR_ROW_BASE + 8'(4 * i), 0, rd);
            chk("cleared", rd, 0);
        end
        wb(0, `SRR_RSRC_OFF, 0, rd);
        chk("resources", rd & 32'hffff, 32'(`SRR_RSRC_RESET));
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
